// ===== rtl/cdp_config_pins.sv
`timescale 1ns/1ps
`default_nettype none
module cdp_config_pins
(
    // clock, reset, enable
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic                   clk_en,
    // oscillator used for the master clock
    input  wire logic                   osc_clk,
    // configuration engine
    input  wire cdp_pkg::cdp_setup_type setup,
    input  wire logic                   init_request,
    input  wire logic                   load_complete,
    input  wire logic                   load_error,
    input  wire logic                   freq_accept,
    input  wire logic                   scan_config,
    input  wire logic                   scan_cell,
    // master byte stream to and from flash
    input  wire logic [7:0]             master_tx_byte,
    output logic                        master_rx_valid,
    output logic [7:0]                  master_rx_byte,
    // status
    output logic                        internal_done,
    output logic                        user_mode,
    output logic                        slave_access,
    // status pin, open drain
    input  wire logic                   status_pin_i,
    output logic                        status_pin_o,
    output logic                        status_pin_oe,
    // shared spi pins
    input  wire logic                   slave_config_clock,
    output logic                        master_clock_o,
    output logic                        master_clock_oe,
    output logic                        flash_chip_select,
    output logic                        flash_chip_select_oe,
    input  wire logic                   slave_data_in,
    output logic                        master_data_out,
    output logic                        master_data_out_oe,
    input  wire logic                   master_data_in,
    output logic                        slave_data_out,
    output logic                        slave_data_out_oe,
    input  wire logic                   slave_port_select_n
);

    cdp_pkg::cdp_state_type state;
    cdp_pkg::cdp_state_type next_state;
    logic [1:0] status_sync;
    logic [1:0] select_sync;
    logic       status_in;
    logic       select_n;
    logic       master_active;
    logic       slave_allowed;
    logic [4:0] freq_code;
    logic       master_run;
    logic [1:0] run_sync;
    logic [4:0] osc_code;
    logic [4:0] next_code;
    logic [1:0] code_sync;
    logic       code_toggle;
    logic       code_seen;
    logic [6:0] osc_count;
    logic       osc_level;
    logic [2:0] bit_index;
    logic [7:0] rx_shift;
    logic       rx_toggle;
    logic [2:0] rx_sync;
    logic [7:0] rx_hold;
    logic [7:0] slave_shift;

    // half period of each master clock choice in oscillator cycles
    function automatic logic [6:0] half_div(input logic [4:0] code);
        logic [6:0] r;
        r = 7'h40;
        case (code)
            5'h00: r = 7'h40;
            5'h01: r = 7'h36;
            5'h02: r = 7'h2A;
            5'h03: r = 7'h1F;
            5'h04: r = 7'h18;
            5'h05: r = 7'h13;
            5'h06: r = 7'h10;
            5'h07: r = 7'h0E;
            5'h08: r = 7'h0D;
            5'h09: r = 7'h0A;
            5'h0A: r = 7'h09;
            5'h0B: r = 7'h06;
            5'h0C: r = 7'h05;
            5'h0D: r = 7'h05;
            5'h0E: r = 7'h04;
            5'h0F: r = 7'h04;
            5'h10: r = 7'h03;
            5'h11: r = 7'h03;
            5'h12: r = 7'h02;
            5'h13: r = 7'h02;
            5'h14: r = 7'h01;
            default: r = 7'h40;
        endcase
        return r;
    endfunction : half_div

    // pin synchronisers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_sync <= 2'h0;
            select_sync <= 2'h3;
        end
        else if (clk_en)
        begin
            status_sync <= {status_sync[0], status_pin_i};
            select_sync <= {select_sync[0], slave_port_select_n};
        end
    end
    assign status_in = status_sync[1];
    assign select_n  = select_sync[1];

    // configuration sequence
    always_comb
    begin
        next_state = state;
        case (state)
            cdp_pkg::CDP_INIT:   next_state = scan_config ? cdp_pkg::CDP_SCAN
                                                          : cdp_pkg::CDP_CONFIG;
            cdp_pkg::CDP_CONFIG:
                if (load_error) next_state = cdp_pkg::CDP_ERROR;
                else if (load_complete) next_state = cdp_pkg::CDP_WAKE;
            cdp_pkg::CDP_WAKE:
                // stall only when the pin is enabled and settings programmed
                if (!(setup.self_download_port_setting && setup.feature_programmed)
                    || status_in)
                    next_state = cdp_pkg::CDP_USER;
            cdp_pkg::CDP_SCAN:   if (!scan_config) next_state = cdp_pkg::CDP_WAKE;
            cdp_pkg::CDP_USER:   next_state = cdp_pkg::CDP_USER;
            cdp_pkg::CDP_ERROR:  next_state = cdp_pkg::CDP_ERROR;
            default:             next_state = cdp_pkg::CDP_INIT;
        endcase
        if (init_request) next_state = cdp_pkg::CDP_INIT;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn) state <= cdp_pkg::CDP_INIT;
        else if (clk_en) state <= next_state;
    end

    // done bit set on wake entry, cleared on init or error
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn) internal_done <= 1'b0;
        else if (clk_en)
            internal_done <= (next_state == cdp_pkg::CDP_WAKE)
                          || (next_state == cdp_pkg::CDP_USER);
    end
    assign user_mode = (state == cdp_pkg::CDP_USER);

    // status pin: with self_download_port_setting, low while not done, released at completion; follows scan cell in scan
    always_comb
    begin
        status_pin_o  = 1'b0;
        status_pin_oe = 1'b0;
        if (state == cdp_pkg::CDP_SCAN)
        begin
            status_pin_o  = scan_cell;
            status_pin_oe = !scan_cell;
        end
        else if (setup.self_download_port_setting)
            status_pin_oe = !internal_done;
    end

    // port arbitration
    assign slave_allowed = !user_mode || setup.slave_port_enable;
    assign slave_access  = slave_allowed && !select_n;
    assign master_active = setup.master_boot && (state == cdp_pkg::CDP_CONFIG)
                        && !slave_access;

    // frequency code: default until accepted; toggle flags a new code
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            freq_code   <= cdp_pkg::FREQ_DEFAULT;
            code_toggle <= 1'b0;
        end
        else if (clk_en)
        begin
            if (state == cdp_pkg::CDP_INIT)
            begin
                if (freq_code != cdp_pkg::FREQ_DEFAULT)
                begin
                    freq_code   <= cdp_pkg::FREQ_DEFAULT;
                    code_toggle <= !code_toggle;
                end
            end
            else if (freq_accept
                     && setup.master_clock_freq_select < 5'(cdp_pkg::FREQ_COUNT))
            begin
                freq_code   <= setup.master_clock_freq_select;
                code_toggle <= !code_toggle;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn) master_run <= 1'b0;
        else if (clk_en) master_run <= master_active;
    end

    // oscillator domain: level and code toggle cross by two flops
    always_ff @(posedge osc_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            run_sync  <= 2'h0;
            code_sync <= 2'h0;
            code_seen <= 1'b0;
            osc_code  <= cdp_pkg::FREQ_DEFAULT;
        end
        else
        begin
            run_sync  <= {run_sync[0], master_run};
            code_sync <= {code_sync[0], code_toggle};
            osc_code  <= next_code;
            if (!osc_level && osc_count == 7'h00)
                code_seen <= code_sync[1];
        end
    end

    // take a new code only while the clock is low; word is stable by then
    always_comb
    begin
        next_code = osc_code;
        if (!osc_level && osc_count == 7'h00 && code_sync[1] != code_seen)
            next_code = freq_code;
    end

    // divider producing the master clock
    always_ff @(posedge osc_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            osc_count <= 7'h00;
            osc_level <= 1'b0;
        end
        else if (!run_sync[1])
        begin
            osc_count <= 7'h00;
            osc_level <= 1'b0;
        end
        else if (osc_count + 7'h01 >= half_div(osc_code))
        begin
            osc_count <= 7'h00;
            osc_level <= !osc_level;
        end
        else osc_count <= osc_count + 7'h01;
    end

    // master shift register on master clock edges
    always_ff @(posedge osc_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bit_index <= 3'h0;
            rx_shift  <= 8'h00;
            rx_toggle <= 1'b0;
        end
        else if (!run_sync[1]) bit_index <= 3'h0;
        else if (!osc_level && osc_count + 7'h01 >= half_div(osc_code))
        begin
            rx_shift  <= {rx_shift[6:0], master_data_in};
            bit_index <= bit_index + 3'h1;
            if (bit_index == 3'h7) rx_toggle <= !rx_toggle;
        end
    end

    // received byte handed back by toggle
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_sync         <= 3'h0;
            rx_hold         <= 8'h00;
            master_rx_valid <= 1'b0;
            master_rx_byte  <= 8'h00;
        end
        else if (clk_en)
        begin
            rx_sync         <= {rx_sync[1:0], rx_toggle};
            rx_hold         <= rx_shift;
            master_rx_valid <= rx_sync[2] ^ rx_sync[1];
            if (rx_sync[2] ^ rx_sync[1]) master_rx_byte <= rx_hold;
        end
    end

    // master pins: driven only during load, else high impedance
    assign master_clock_o       = osc_level;
    assign master_clock_oe      = run_sync[1];
    assign flash_chip_select    = 1'b0;
    assign flash_chip_select_oe = master_active;
    assign master_data_out      = master_tx_byte[~bit_index];
    assign master_data_out_oe   = master_active;

    // slave port on the external clock
    always_ff @(negedge slave_config_clock or negedge resetn)
    begin
        if (!resetn) slave_shift <= 8'h00;
        else slave_shift <= {slave_shift[6:0], slave_data_in};
    end
    assign slave_data_out    = slave_shift[7];
    assign slave_data_out_oe = slave_access && !master_active;

endmodule : cdp_config_pins
`default_nettype wire

// ===== rtl/cdp_pkg.sv
// Behaviour
// - status pin open-drain, released high means user
// - status pin low from initialization through configuration
// - default mode: pin is I/O, auto wake-up
// - enabled pin held low stalls wake-up
// - test-access load: pin follows scan cell
// - pin released immediately on successful completion
// - master mode drives clock, select, data out
// - slave mode drives only outgoing data
// - default mode: shared clock is slave clock
// - slave reprogramming in user mode needs enable
// - master clock driven until loaded, then tristate
// - master clock from oscillator, starts 2.08 MHz
// - frequency select picks one of twenty-one values
// - selected frequency applied once value accepted
// - slave select works default mode or enabled
// - slave select low deasserts flash select
// - master and slave ports time-multiplexed
// - flash select asserted until all bytes loaded
// - master data out driven until loaded
// - error keeps done clear, pin low
package cdp_pkg;

    // master clock oscillator rate, number of frequency choices, default code and divider width
    localparam int unsigned OSC_HZ         = 266000000;
    localparam int unsigned FREQ_COUNT     = 21;
    localparam logic [4:0]  FREQ_DEFAULT   = 5'h00;
    localparam logic [6:0]  HALF_DIV_WIDTH = 7'h07;

    typedef enum logic [5:0]
    {
        CDP_INIT   = 6'h01,
        CDP_CONFIG = 6'h02,
        CDP_WAKE   = 6'h04,
        CDP_USER   = 6'h08,
        CDP_ERROR  = 6'h10,
        CDP_SCAN   = 6'h20
    } cdp_state_type;

    // device personality captured from nonvolatile settings
    typedef struct packed
    {
        logic       feature_programmed;
        logic       self_download_port_setting;
        logic       slave_port_enable;
        logic       master_boot;
        logic [4:0] master_clock_freq_select;
    } cdp_setup_type;

    // drive side of one open-drain or two-way pin as two signals
    typedef struct packed
    {
        logic o;
        logic oe;
    } cdp_pin_drive_type;

endpackage : cdp_pkg

// ===== tb/cdp_config_pins_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cdp_config_pins_asserts
(
    // clock and reset
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    // inputs seen
    input wire cdp_pkg::cdp_setup_type setup,
    input wire logic                   load_complete,
    input wire logic                   load_error,
    input wire logic                   slave_port_select_n,
    input wire logic                   status_pin_i,
    // outputs checked
    input wire logic                   internal_done,
    input wire logic                   user_mode,
    input wire logic                   slave_access,
    input wire logic                   status_pin_o,
    input wire logic                   status_pin_oe,
    input wire logic                   master_clock_oe,
    input wire logic                   flash_chip_select,
    input wire logic                   flash_chip_select_oe,
    input wire logic                   master_data_out_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // pin held low may stall wake-up
    wire stall = setup.self_download_port_setting & setup.feature_programmed;
    // cycles spent in user mode, saturating; leaves room for the oscillator crossing
    logic [3:0] user_cycles;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn) user_cycles <= 4'h0;
        else if (!user_mode) user_cycles <= 4'h0;
        else if (user_cycles != 4'hF) user_cycles <= user_cycles + 4'h1;
    end
    property p_od; status_pin_oe |-> !status_pin_o; endproperty
    a_od: assert property (p_od) else $error("status pin driven high");
    property p_cs; flash_chip_select_oe |-> !flash_chip_select; endproperty
    a_cs: assert property (p_cs) else $error("flash select driven high");
    property p_done; $rose(internal_done) |-> $past(load_complete) && !status_pin_oe; endproperty
    a_done: assert property (p_done) else $error("done without release");
    property p_err;
        load_error && !internal_done |=>
            !internal_done && (status_pin_oe || !setup.self_download_port_setting);
    endproperty
    a_err: assert property (p_err) else $error("error let done through");
    property p_wake; $rose(internal_done) && !stall |=> user_mode; endproperty
    a_wake: assert property (p_wake) else $error("no automatic wake-up");
    property p_stall;
        stall && !user_mode && !status_pin_i && !$past(status_pin_i)
            && !$past(status_pin_i, 2) |=> !user_mode;
    endproperty
    a_stall: assert property (p_stall) else $error("woke with pin held low");
    property p_user; user_mode && !setup.slave_port_enable |-> !slave_access; endproperty
    a_user: assert property (p_user) else $error("slave access in user mode");
    property p_sel;
        !slave_port_select_n [*4] |-> !flash_chip_select_oe && !master_data_out_oe;
    endproperty
    a_sel: assert property (p_sel) else $error("flash kept with slave select");
    property p_tri;
        user_cycles == 4'hF |-> !master_clock_oe && !flash_chip_select_oe && !master_data_out_oe;
    endproperty
    a_tri: assert property (p_tri) else $error("master pins kept in user");
    // main scenarios reached
    c_user: cover property ($rose(user_mode));
    c_err: cover property (load_error && !internal_done);
    c_slave: cover property (slave_access && !slave_port_select_n);
endmodule : cdp_config_pins_asserts
bind cdp_config_pins cdp_config_pins_asserts u_chk
(
    .sys_clk(sys_clk), .resetn(resetn), .setup(setup), .load_complete(load_complete),
    .load_error(load_error), .slave_port_select_n(slave_port_select_n),
    .status_pin_i(status_pin_i), .internal_done(internal_done), .user_mode(user_mode),
    .slave_access(slave_access), .status_pin_o(status_pin_o), .status_pin_oe(status_pin_oe),
    .master_clock_oe(master_clock_oe), .flash_chip_select(flash_chip_select),
    .flash_chip_select_oe(flash_chip_select_oe), .master_data_out_oe(master_data_out_oe)
);
`default_nettype wire

// ===== tb/cdp_config_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cdp_config_pins_tb;
    logic sys_clk = 1'b0, osc_clk = 1'b0, resetn = 1'b0, hold_low = 1'b0, sn = 1'b1, sclk = 1'b0;
    logic [3:0] ev = 4'h0; // init, complete, error, accept
    cdp_pkg::cdp_setup_type setup = 9'h1A0;
    logic [7:0] exp_byte = 8'hA5;
    int miscompares = 0, checks = 0, cycles = 0, p;
    wire logic [7:0] rx_byte;
    wire logic rx_valid, done, user, access, st_o, st_oe, mclk, mclk_oe, fcs, fcs_oe;
    wire logic so, so_oe, mdo, mdo_oe, mdi;
    wire logic st_i = st_oe ? st_o : ~hold_low;
    // clocks: system and unrelated oscillator
    initial forever #4 sys_clk = ~sys_clk;
    initial
    begin
        #3;
        forever #15 osc_clk = ~osc_clk;
    end
    cdp_config_pins uut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .osc_clk(osc_clk),
        .setup(setup), .init_request(ev[3]), .load_complete(ev[2]), .load_error(ev[1]),
        .freq_accept(ev[0]), .scan_config(1'b0), .scan_cell(1'b0), .master_tx_byte(8'h00),
        .master_rx_valid(rx_valid), .master_rx_byte(rx_byte), .internal_done(done),
        .user_mode(user), .slave_access(access), .status_pin_i(st_i), .status_pin_o(st_o),
        .status_pin_oe(st_oe), .slave_config_clock(sclk), .master_clock_o(mclk),
        .master_clock_oe(mclk_oe), .flash_chip_select(fcs), .flash_chip_select_oe(fcs_oe),
        .slave_data_in(1'b1), .master_data_out(mdo), .master_data_out_oe(mdo_oe),
        .master_data_in(mdi), .slave_data_out(so), .slave_data_out_oe(so_oe),
        .slave_port_select_n(sn));
    cdp_flash_model u_flash (.clk(mclk_oe ? mclk : 1'b1), .cs(fcs), .cs_oe(fcs_oe), .data_in(mdi));
    task check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task fire(input logic [3:0] v);
        @(posedge sys_clk) ev <= v;
        @(posedge sys_clk) ev <= 4'h0;
    endtask : fire
    // master clock period in oscillator cycles
    task measure(output int n);
        logic lo;
        @(posedge mclk);
        n = 0;
        lo = 1'b0;
        while (!(lo && mclk === 1'b1) && n < 400)
        begin
            @(posedge osc_clk);
            #1;
            n++;
            if (mclk === 1'b0)
                lo = 1'b1;
        end
    endtask : measure
    // every byte from flash compared in order
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            miscompares++;
            print_verdict();
        end
        if (rx_valid === 1'b1)
        begin
            check(rx_byte, exp_byte);
            exp_byte <= exp_byte + 8'h3B;
        end
    end
    initial
    begin
        tick(10);
        check({done, st_oe, mclk_oe}, 8'h2);
        @(posedge sys_clk) resetn <= 1'b1;
        $display("test reset done");
        tick(20);
        check({mclk_oe, fcs_oe, fcs, mdo_oe, st_oe}, 8'h1B);
        measure(p);
        check(8'(p >= 120 && p <= 136), 8'h1);
        @(posedge sys_clk) setup.master_clock_freq_select <= 5'h14;
        fire(4'h1);
        measure(p);
        measure(p);
        check(8'(p), 8'h2);
        tick(600);
        $display("test master load done");
        @(posedge sys_clk iff rx_valid === 1'b1) hold_low <= 1'b1;
        fire(4'h4);
        tick(1);
        check({done, st_oe}, 8'h2);
        tick(10);
        check(user, 1'b0);
        @(posedge sys_clk) hold_low <= 1'b0;
        tick(5);
        check(user, 1'b1);
        tick(20);
        check({mclk_oe, fcs_oe, mdo_oe, access}, 8'h0);
        $display("test stall done");
        fire(4'h8);
        tick(3);
        check({user, done, st_oe}, 8'h1);
        fire(4'h2);
        tick(3);
        check({done, st_oe}, 8'h1);
        $display("test error done");
        @(posedge sys_clk) setup <= 9'h140;
        hold_low <= 1'b1;
        fire(4'h8);
        @(posedge sys_clk) sn <= 1'b0;
        repeat (16) #15 sclk = ~sclk;
        tick(1);
        check({access, so_oe, fcs_oe, mclk_oe, so}, 8'h19);
        @(posedge sys_clk) sn <= 1'b1;
        fire(4'h4);
        tick(2);
        check(user, 1'b1);
        $display("test default mode done");
        print_verdict();
    end
endmodule : cdp_config_pins_tb
`default_nettype wire

// ===== tb/cdp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdp_flash_model
(
    // flash side pins
    input  wire logic clk,
    input  wire logic cs,
    input  wire logic cs_oe,
    output logic      data_in
);
    logic [2:0] idx = 3'h0;
    logic [7:0] cur = 8'hA5;
    wire        off = cs | ~cs_oe;
    // bit count per rising clock, next byte after eight
    always @(posedge clk or posedge off)
    begin
        if (off)
            idx <= 3'h0;
        else
        begin
            idx <= idx + 3'h1;
            if (idx == 3'h7)
                cur <= cur + 8'h3B;
        end
    end
    // msb first; released line shows the inverted bit
    assign data_in = off ? ~cur[3'h7 - idx] : cur[3'h7 - idx];
endmodule : cdp_flash_model
`default_nettype wire
